// ### hw/ssc_col_sync.sv
// Per-column comparator bus capture and end-of-conversion latch
`timescale 1ns/1ps
`include "ssc_defines.svh"

module ssc_col_sync (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Column inputs, already synchronised
  input wire ssc_pkg::ssc_col_in_t col_i,
  input wire logic phase2_rise_i,
  // Control
  input wire ssc_pkg::ssc_sync_sel_t sync_sel_i,
  input wire logic bypass_i,
  input wire logic bus_source_i,
  input wire logic conv_enable_i,
  input wire logic auto_seq_i,
  // Results
  output logic bus_bit_o,
  output logic end_state_o
);

  typedef struct packed {
    logic clk_prev;
    logic gate_prev;
    logic bus;
    logic end_state;
    logic tripped;
  } ssc_cs_state_t;

  ssc_cs_state_t st_q;
  ssc_cs_state_t st_d;
  logic col_rise;
  logic gate_fall;
  logic gated_cmp;
  logic src_bit;
  logic take;

  // ----------------------------------------------------------------------
  // Edge detection and next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    col_rise = col_i.column_clock & ~st_q.clk_prev;
    gate_fall = ~col_i.pwm_gate & st_q.gate_prev;
    gated_cmp = col_i.comparator & col_i.pwm_gate;
    // Source select: gated comparator or PWM terminal count
    src_bit = bus_source_i ? col_i.pwm_term_count : gated_cmp;
    // Capture edge select
    take = (sync_sel_i == ssc_pkg::SSC_SYNC_COLCLK) ? col_rise : phase2_rise_i;
    st_d.clk_prev = col_i.column_clock;
    st_d.gate_prev = col_i.pwm_gate;
    if (bypass_i) begin
      st_d.bus = src_bit;
    end else if (take) begin
      st_d.bus = src_bit;
    end
    // Trip tracking over the ramp, closed by gate fall
    if (conv_enable_i && auto_seq_i && col_i.pwm_gate && col_i.comparator) begin
      st_d.tripped = 1'b1;
    end
    if (gate_fall && conv_enable_i) begin
      st_d.end_state = ~(st_q.tripped | col_i.comparator);
      st_d.tripped = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '{clk_prev: 1'b0, gate_prev: 1'b0, bus: 1'b0,
                end_state: `SSC_END_STATE_RESET, tripped: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_bit_o = st_q.bus;
  assign end_state_o = st_q.end_state;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  phase2_capture_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!bypass_i && sync_sel_i == ssc_pkg::SSC_SYNC_PHASE2 && phase2_rise_i && bus_source_i)
    |=> bus_bit_o == $past(col_i.pwm_term_count))
    else $error("bus bit not taken on phase two edge");
  colclk_capture_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!bypass_i && sync_sel_i == ssc_pkg::SSC_SYNC_COLCLK && !col_rise && !bus_source_i)
    |=> $stable(bus_bit_o))
    else $error("bus bit changed off column clock edge");
  end_state_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !gate_fall |=> $stable(end_state_o))
    else $error("end state changed without gate fall");
  trip_clear_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (gate_fall && conv_enable_i && col_i.comparator) |=> !end_state_o)
    else $error("end state not cleared on trip");
  bypass_follow_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (bypass_i && !bus_source_i) |=> bus_bit_o == $past(gated_cmp))
    else $error("bypass did not follow source");

endmodule

// ### hw/ssc_ctrl.sv
// Single-slope converter column control with register port
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "ssc_defines.svh"

// Summary of operation
// - With clock select 0, bus bit is captured on rising second phase clock.
// - With clock select 1, bus bit is captured on undivided column clock rising edge.
// - End state latched at gate PWM fall: 0 if comparator tripped, else 1.
// - Range bit 1 selects about one quarter current, 0 normal range.
// - Sample-hold enable switches hold on the positive comparator input.
// - Bus source 0 drives bus with synchronised, window-gated comparator.
// - Bus source 1 drives bus with selected PWM terminal count.
// - Auto sequencing lets PWM drive ramp and sample-hold; software sets it.
// - Converter enable 1 powers column up; 0 powers it down.
// - Column 0 config at 68h, column 1 config at 69h.
// - Latch bypass bit skips bus synchronisation for sleep wakeup.
module ssc_ctrl #(
  parameter int NUM_COLS = 2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [`SSC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Asynchronous column inputs
  input wire ssc_pkg::ssc_col_in_t col0_i,
  input wire ssc_pkg::ssc_col_in_t col1_i,
  input wire logic phase2_clk_i,
  // Column controls and comparator bus
  output ssc_pkg::ssc_col_ctl_t col0_ctl_o,
  output ssc_pkg::ssc_col_ctl_t col1_ctl_o,
  output logic [1:0] cmp_bus_o
);

  initial begin
    if (NUM_COLS != 2) begin
      $error("only two columns are supported");
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] sync_ctl;
    logic [7:0] rdata;
    ssc_pkg::ssc_col_in_t c0_m;
    ssc_pkg::ssc_col_in_t c0_s;
    ssc_pkg::ssc_col_in_t c1_m;
    ssc_pkg::ssc_col_in_t c1_s;
    logic ph2_m;
    logic ph2_s;
    logic ph2_prev;
    ssc_pkg::ssc_col_ctl_t ctl0;
    ssc_pkg::ssc_col_ctl_t ctl1;
    logic [1:0] bus;
  } ssc_state_t;

  ssc_state_t st_q;
  ssc_state_t st_d;
  logic [1:0] bus_bit;
  logic [1:0] end_state;
  logic ph2_rise;

  // Map config bits onto the analog column controls
  function automatic ssc_pkg::ssc_col_ctl_t cfg_to_ctl(input logic [7:0] cfg);
    ssc_pkg::ssc_col_ctl_t c;
    c.conv_enable = cfg[`SSC_BIT_CONV_EN];
    c.auto_seq = cfg[`SSC_BIT_AUTO_SEQ] & cfg[`SSC_BIT_CONV_EN];
    c.bus_source = cfg[`SSC_BIT_BUS_SRC];
    c.sample_hold_enable = cfg[`SSC_BIT_SH_EN] & cfg[`SSC_BIT_CONV_EN];
    c.low_current_range = cfg[`SSC_BIT_LOW_RANGE];
    return c;
  endfunction

  // Readback with live end-of-conversion state
  function automatic logic [7:0] cfg_view(input logic [7:0] cfg, input logic es);
    logic [7:0] v;
    v = cfg & `SSC_CFG_WR_MASK;
    v[`SSC_BIT_END_STATE] = es;
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Column capture
  // ----------------------------------------------------------------------
  ssc_col_sync u_col0 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .col_i(st_q.c0_s),
    .phase2_rise_i(ph2_rise),
    .sync_sel_i(ssc_pkg::ssc_sync_sel_t'(st_q.sync_ctl[`SSC_BIT_CLKSEL0])),
    .bypass_i(st_q.sync_ctl[`SSC_BIT_BYPASS0]),
    .bus_source_i(st_q.cfg0[`SSC_BIT_BUS_SRC]),
    .conv_enable_i(st_q.cfg0[`SSC_BIT_CONV_EN]),
    .auto_seq_i(st_q.cfg0[`SSC_BIT_AUTO_SEQ]),
    .bus_bit_o(bus_bit[0]),
    .end_state_o(end_state[0])
  );

  ssc_col_sync u_col1 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .col_i(st_q.c1_s),
    .phase2_rise_i(ph2_rise),
    .sync_sel_i(ssc_pkg::ssc_sync_sel_t'(st_q.sync_ctl[`SSC_BIT_CLKSEL1])),
    .bypass_i(st_q.sync_ctl[`SSC_BIT_BYPASS1]),
    .bus_source_i(st_q.cfg1[`SSC_BIT_BUS_SRC]),
    .conv_enable_i(st_q.cfg1[`SSC_BIT_CONV_EN]),
    .auto_seq_i(st_q.cfg1[`SSC_BIT_AUTO_SEQ]),
    .bus_bit_o(bus_bit[1]),
    .end_state_o(end_state[1])
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    ph2_rise = st_q.ph2_s & ~st_q.ph2_prev;
    // Two-stage synchronisers on pins
    st_d.c0_m = col0_i;
    st_d.c0_s = st_q.c0_m;
    st_d.c1_m = col1_i;
    st_d.c1_s = st_q.c1_m;
    st_d.ph2_m = phase2_clk_i;
    st_d.ph2_s = st_q.ph2_m;
    st_d.ph2_prev = st_q.ph2_s;
    // Register writes; reserved bits forced to zero
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SSC_OFF_COL0_CFG: begin
          st_d.cfg0 = reg_wdata_i & `SSC_CFG_WR_MASK;
        end
        `SSC_OFF_COL1_CFG: begin
          st_d.cfg1 = reg_wdata_i & `SSC_CFG_WR_MASK;
        end
        `SSC_OFF_SYNC_CTL: begin
          st_d.sync_ctl = reg_wdata_i & `SSC_SYNC_WR_MASK;
        end
        default: begin
          st_d.cfg0 = st_q.cfg0;
        end
      endcase
    end
    // Register reads, data one cycle later; unmapped reads zero
    st_d.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SSC_OFF_COL0_CFG: begin
          st_d.rdata = cfg_view(st_q.cfg0, end_state[0]);
        end
        `SSC_OFF_COL1_CFG: begin
          st_d.rdata = cfg_view(st_q.cfg1, end_state[1]);
        end
        `SSC_OFF_SYNC_CTL: begin
          st_d.rdata = st_q.sync_ctl;
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
    // Column controls from current config
    st_d.ctl0 = cfg_to_ctl(st_q.cfg0);
    st_d.ctl1 = cfg_to_ctl(st_q.cfg1);
    st_d.bus = bus_bit;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign col0_ctl_o = st_q.ctl0;
  assign col1_ctl_o = st_q.ctl1;
  assign cmp_bus_o = st_q.bus;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  reset_clear_a: assert property (@(posedge ref_clk_i)
    $past(sys_rst_i) |-> (st_q.cfg0 == `SSC_CFG_RESET && st_q.cfg1 == `SSC_CFG_RESET
                          && !col0_ctl_o.conv_enable && !col0_ctl_o.auto_seq))
    else $error("config not cleared by reset");
  write_col0_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_wr_i && reg_addr_i == `SSC_OFF_COL0_CFG) |=> ##1
      col0_ctl_o.conv_enable == $past(reg_wdata_i[`SSC_BIT_CONV_EN], 2))
    else $error("column 0 enable not written");
  reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (st_q.cfg1 & ~`SSC_CFG_WR_MASK) == 8'h00)
    else $error("reserved config bit set");
  range_map_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    col1_ctl_o.low_current_range == $past(st_q.cfg1[`SSC_BIT_LOW_RANGE]))
    else $error("range control mismatch");
  power_down_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !$past(st_q.cfg0[`SSC_BIT_CONV_EN]) |-> (!col0_ctl_o.conv_enable
                                             && !col0_ctl_o.sample_hold_enable))
    else $error("column 0 not powered down");
  auto_seq_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    col0_ctl_o.auto_seq |-> col0_ctl_o.conv_enable)
    else $error("sequencing without enable");
  sh_map_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(st_q.cfg1[`SSC_BIT_SH_EN] && st_q.cfg1[`SSC_BIT_CONV_EN])
      |-> col1_ctl_o.sample_hold_enable)
    else $error("sample hold not enabled");
  bus_out_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    cmp_bus_o == $past(bus_bit))
    else $error("comparator bus not registered");
  read_once_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");

  cov_write0_c: cover property (@(posedge ref_clk_i) reg_wr_i && reg_addr_i == `SSC_OFF_COL0_CFG);
  cov_endread_c: cover property (@(posedge ref_clk_i) reg_rd_i ##1 reg_rdata_o[7]);
  cov_bus_c: cover property (@(posedge ref_clk_i) $rose(cmp_bus_o[0]));
  cov_colclk_c: cover property (@(posedge ref_clk_i) st_q.sync_ctl[`SSC_BIT_CLKSEL1] && $rose(cmp_bus_o[1]));

endmodule

// ### pkg/ssc_defines.svh
// Register offsets, field positions and reset values of the column converter control
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SSC_ADDR_W 8
`define SSC_OFF_COL0_CFG 8'h68
`define SSC_OFF_COL1_CFG 8'h69
`define SSC_OFF_SYNC_CTL 8'h66

// ----------------------------------------------------------------------
// Column config fields
// ----------------------------------------------------------------------
`define SSC_BIT_END_STATE 7
`define SSC_BIT_LOW_RANGE 6
`define SSC_BIT_SH_EN 5
`define SSC_BIT_BUS_SRC 3
`define SSC_BIT_AUTO_SEQ 2
`define SSC_BIT_CONV_EN 0
`define SSC_CFG_WR_MASK 8'h6D
`define SSC_CFG_RESET 8'h00

// ----------------------------------------------------------------------
// Sync control fields
// ----------------------------------------------------------------------
`define SSC_BIT_BYPASS0 4
`define SSC_BIT_BYPASS1 5
`define SSC_BIT_CLKSEL0 0
`define SSC_BIT_CLKSEL1 1
`define SSC_SYNC_WR_MASK 8'h33
`define SSC_SYNC_RESET 8'h00
`define SSC_END_STATE_RESET 1'b1

`endif

// ### pkg/ssc_pkg.sv
// Types shared by the column converter control block
package ssc_pkg;

  // Per-column converter controls toward the analog column
  typedef struct packed {
    logic conv_enable;
    logic auto_seq;
    logic bus_source;
    logic sample_hold_enable;
    logic low_current_range;
  } ssc_col_ctl_t;

  // Per-column digital inputs
  typedef struct packed {
    logic comparator;
    logic pwm_gate;
    logic pwm_term_count;
    logic column_clock;
  } ssc_col_in_t;

  // Capture edge select
  typedef enum logic [0:0] {
    SSC_SYNC_PHASE2 = 1'b0,
    SSC_SYNC_COLCLK = 1'b1
  } ssc_sync_sel_t;

endpackage

// ### testbench/ssc_col_model.sv
// Behavioural model of the analog columns, their PWM pins and clock sources
`timescale 1ns/1ps

module ssc_col_model (
  // Clock
  input wire logic ref_clk_i,
  // Column behaviour chosen by the bench
  input wire logic p2_run_i,
  input wire logic cc_run_i,
  input wire logic [1:0] cmp_i,
  input wire logic [1:0] gate_i,
  input wire logic [1:0] tc_i,
  // Column pins toward the block
  output ssc_pkg::ssc_col_in_t col0_o,
  output ssc_pkg::ssc_col_in_t col1_o,
  output logic phase2_o
);
  logic [3:0] div_q = 4'h0;
  logic p2_q = 1'b0;
  logic cc_q = 1'b0;

  // Free divider; both clocks stand low while stopped
  always_ff @(posedge ref_clk_i) begin
    div_q <= div_q + 4'h1;
    p2_q <= p2_run_i & div_q[3];
    cc_q <= cc_run_i & div_q[1];
  end

  // Pins, packed in struct order
  assign phase2_o = p2_q;
  assign col0_o = {cmp_i[0], gate_i[0], tc_i[0], cc_q};
  assign col1_o = {cmp_i[1], gate_i[1], tc_i[1], cc_q};
endmodule

// ### testbench/ssc_ctrl_tb.sv
// Self-checking bench for the column converter control block
`timescale 1ns/1ps

module ssc_ctrl_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic p2_run = 1'b0;
  logic cc_run = 1'b0;
  logic [1:0] cmp = 2'h0;
  logic [1:0] gate = 2'h0;
  logic [1:0] tc = 2'h0;
  logic phase2;
  logic [1:0] cmp_bus;
  ssc_pkg::ssc_col_in_t col0;
  ssc_pkg::ssc_col_in_t col1;
  ssc_pkg::ssc_col_ctl_t ctl0;
  ssc_pkg::ssc_col_ctl_t ctl1;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] rv;

  // 25 MHz clock
  always #20 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  ssc_ctrl u_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .col0_i(col0), .col1_i(col1), .phase2_clk_i(phase2),
    .col0_ctl_o(ctl0), .col1_ctl_o(ctl1), .cmp_bus_o(cmp_bus)
  );

  ssc_col_model u_model (
    .ref_clk_i(ref_clk_i), .p2_run_i(p2_run), .cc_run_i(cc_run),
    .cmp_i(cmp), .gate_i(gate), .tc_i(tc),
    .col0_o(col0), .col1_o(col1), .phase2_o(phase2)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("mismatches %0d of %0d compares", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk_i);
    reg_wr <= 1'b0;
  endtask

  // Read data stand in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic drive(input logic [1:0] c, input logic [1:0] g, input logic [1:0] t,
                       input logic p, input logic k);
    @(posedge ref_clk_i);
    cmp <= c;
    gate <= g;
    tc <= t;
    p2_run <= p;
    cc_run <= k;
  endtask

  // Bounded wait for one bus bit to reach a level
  task automatic wait_bus(input int idx, input logic exp);
    int n;
    n = 0;
    while (cmp_bus[idx] !== exp && n < 80) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (cmp_bus[idx] !== exp) begin
      fail_count++;
      $display("unexpected at %0t: bus bit wait ran out", $time);
      complete_run();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd(8'h68, rv);
    check(rv, 8'h80);
    rd(8'h69, rv);
    check(rv, 8'h80);
    rd(8'h66, rv);
    check(rv, 8'h00);
    check({3'h0, ctl0}, 8'h00);
    check({6'h0, cmp_bus}, 8'h00);
  endtask

  task automatic t_config();
    wr(8'h68, 8'h6D);
    idle(2);
    check({3'h0, ctl0}, 8'h1F);
    check({3'h0, ctl1}, 8'h00);
    rd(8'h68, rv);
    check(rv, 8'hED);
    wr(8'h69, 8'h60);
    idle(2);
    check({3'h0, ctl1}, 8'h01);
    rd(8'h69, rv);
    check(rv, 8'hE0);
    wr(8'h6A, 8'h6D);
    rd(8'h6A, rv);
    check(rv, 8'h00);
  endtask

  // Bus source 1 follows the PWM terminal count
  task automatic t_term_count();
    drive(2'h0, 2'h0, 2'h1, 1'b1, 1'b0);
    wait_bus(0, 1'b1);
    check({7'h0, cmp_bus[0]}, 8'h01);
    drive(2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
    wait_bus(0, 1'b0);
    check({7'h0, cmp_bus[0]}, 8'h00);
  endtask

  // Capture edge selection and window-gated comparator
  task automatic t_sync();
    wr(8'h68, 8'h05);
    drive(2'h1, 2'h1, 2'h0, 1'b0, 1'b1);
    idle(40);
    check({7'h0, cmp_bus[0]}, 8'h00);
    drive(2'h1, 2'h1, 2'h0, 1'b1, 1'b1);
    wait_bus(0, 1'b1);
    check({7'h0, cmp_bus[0]}, 8'h01);
    drive(2'h1, 2'h0, 2'h0, 1'b1, 1'b1);
    wait_bus(0, 1'b0);
    check({7'h0, cmp_bus[0]}, 8'h00);
    wr(8'h66, 8'h01);
    drive(2'h1, 2'h1, 2'h0, 1'b0, 1'b1);
    wait_bus(0, 1'b1);
    check({7'h0, cmp_bus[0]}, 8'h01);
  endtask

  // End state latched at gate fall, only while enabled
  task automatic t_end_state();
    // Close the ramp left open by the sync scenario, clearing its trip
    drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
    idle(8);
    drive(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
    idle(6);
    drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
    idle(8);
    rd(8'h68, rv);
    check(rv, 8'h85);
    drive(2'h1, 2'h1, 2'h0, 1'b0, 1'b0);
    idle(6);
    drive(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
    idle(6);
    drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
    idle(8);
    rd(8'h68, rv);
    check(rv, 8'h05);
    wr(8'h68, 8'h00);
    drive(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
    idle(6);
    drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
    idle(8);
    rd(8'h68, rv);
    check(rv, 8'h00);
  endtask

  // Bypass passes the bus with both clocks stopped
  task automatic t_bypass();
    wr(8'h66, 8'h30);
    wr(8'h69, 8'h05);
    drive(2'h2, 2'h2, 2'h0, 1'b0, 1'b0);
    wait_bus(1, 1'b1);
    check({7'h0, cmp_bus[1]}, 8'h01);
    drive(2'h0, 2'h2, 2'h0, 1'b0, 1'b0);
    wait_bus(1, 1'b0);
    check({7'h0, cmp_bus[1]}, 8'h00);
    // Column 1 on its own column clock, second phase clock stopped
    wr(8'h66, 8'h02);
    drive(2'h2, 2'h2, 2'h0, 1'b0, 1'b1);
    wait_bus(1, 1'b1);
    check({7'h0, cmp_bus[1]}, 8'h01);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_config();
    t_term_count();
    t_sync();
    t_end_state();
    t_bypass();
    complete_run();
  end
endmodule
